//--- core/clock_stop_spi_port.v
// Clock-stop SPI port with AXI4-Lite register access
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "clock_stop_spi_port_map.vh"

module clock_stop_spi_port (
  input  wire        sys_clk_i,
  input  wire        rst_i,
  input  wire [7:0]  s_axi_awaddr_i,
  input  wire        s_axi_awvalid_i,
  output wire        s_axi_awready_o,
  input  wire [31:0] s_axi_wdata_i,
  input  wire [3:0]  s_axi_wstrb_i,
  input  wire        s_axi_wvalid_i,
  output wire        s_axi_wready_o,
  output reg  [1:0]  s_axi_bresp_o,
  output reg         s_axi_bvalid_o,
  input  wire        s_axi_bready_i,
  input  wire [7:0]  s_axi_araddr_i,
  input  wire        s_axi_arvalid_i,
  output wire        s_axi_arready_o,
  output reg  [31:0] s_axi_rdata_o,
  output reg  [1:0]  s_axi_rresp_o,
  output reg         s_axi_rvalid_o,
  input  wire        s_axi_rready_i,
  input  wire        tx_bitclk_pin_i,
  output wire        tx_bitclk_pin_o,
  output wire        tx_bitclk_pin_oe_o,
  input  wire        tx_sync_pin_i,
  output wire        tx_sync_pin_o,
  output wire        tx_sync_pin_oe_o,
  input  wire        rx_sync_pin_i,
  output reg         serial_out_pin_o,
  output reg         serial_out_pin_oe_o,
  input  wire        serial_in_pin_i
);

  localparam [2:0] ST_IDLE  = 3'b000;
  localparam [2:0] ST_HIGH  = 3'b001;
  localparam [2:0] ST_LOW   = 3'b010;
  localparam [2:0] ST_TAIL  = 3'b011;
  localparam [2:0] ST_SLAVE = 3'b100;

  reg  [31:0] ctrl;
  reg  [7:0]  tx_word;
  reg         tx_pending;
  reg  [7:0]  rx_word;
  reg         rx_ready;
  reg  [2:0]  state;
  reg  [8:0]  cnt;
  reg  [3:0]  bit_cnt;
  reg  [7:0]  tx_shift;
  reg  [7:0]  rx_shift;
  reg         clk_level;
  reg         sync_active;
  reg         prev_nclk;
  reg         aw_held;
  reg         w_held;
  reg  [7:0]  aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  reg  [31:0] next_ctrl;
  reg  [31:0] read_mux;
  reg         read_hit;
  integer     b;

  wire [3:0]  pins_sync;
  wire        s_clk    = pins_sync[0];
  wire        s_txsync = pins_sync[1];
  wire        s_rxsync = pins_sync[2];
  wire        s_in     = pins_sync[3];

  wire        tx_bitclk_polarity    = ctrl[`CTRL_CLKPOL_BIT];
  wire        tx_sync_polarity      = ctrl[`CTRL_TXPOL_BIT];
  wire        rx_sync_polarity      = ctrl[`CTRL_RXPOL_BIT];
  wire        tx_bitclk_dir         = ctrl[`CTRL_TXCLKD_BIT];
  wire        rx_bitclk_dir         = ctrl[`CTRL_RXCLKD_BIT];
  wire        tx_sync_dir           = ctrl[`CTRL_TXSYND_BIT];
  wire        rx_sync_dir           = ctrl[`CTRL_RXSYND_BIT];
  wire        rate_clock_source_sel = ctrl[`CTRL_SRCSEL_BIT];
  wire [1:0]  stop_mode_field       = ctrl[`CTRL_STOP_MSB:`CTRL_STOP_LSB];
  wire [7:0]  rate_divide_value     = ctrl[`CTRL_DIV_MSB:`CTRL_DIV_LSB];

  // Mode selection from the direction bits, the stop mode field and the rate source and divide
  wire stop_ok     = (stop_mode_field == `STOP_MODE_LATE);
  wire master_mode = stop_ok & tx_bitclk_dir & tx_sync_dir
                     & ~rx_bitclk_dir & ~rx_sync_dir;
  wire slave_dirs  = ~tx_bitclk_dir & ~tx_sync_dir
                     & ~rx_bitclk_dir & ~rx_sync_dir;
  wire slave_rate  = rate_clock_source_sel
                     & (rate_divide_value == `SLAVE_RATE_DIV);
  wire slave_mode  = stop_ok & slave_dirs & slave_rate;
  wire cfg_error   = ~master_mode & ~slave_mode;

  // Bit clock phase lengths in system clock cycles
  wire [7:0] eff_div  = (rate_divide_value == 8'h00) ? 8'h01 : rate_divide_value;
  wire [8:0] period   = {1'b0, eff_div} + 9'h001;
  wire [8:0] low_len  = {2'b00, eff_div[7:1]} + {8'h00, eff_div[0]};
  wire [8:0] high_len = {2'b00, eff_div[7:1]} + 9'h001;

  // Slave side views of the pins
  wire nclk   = tx_bitclk_polarity ? s_clk : ~s_clk;
  wire s_rise = nclk & ~prev_nclk;
  wire s_fall = ~nclk & prev_nclk;
  wire tx_act = tx_sync_polarity ? ~s_txsync : s_txsync;
  wire rx_act = rx_sync_polarity ? ~s_rxsync : s_rxsync;

  // Bus handshakes
  wire aw_hs    = s_axi_awvalid_i & s_axi_awready_o;
  wire w_hs     = s_axi_wvalid_i & s_axi_wready_o;
  wire ar_hs    = s_axi_arvalid_i & s_axi_arready_o;
  wire do_write = aw_held & w_held & ~s_axi_bvalid_o;
  wire wr_ctrl  = do_write & (aw_addr[7:2] == `CTRL_OFFSET >> 2);
  wire tx_write = do_write & (aw_addr[7:2] == `TXDATA_OFFSET >> 2);
  wire rx_read  = ar_hs & (s_axi_araddr_i[7:2] == `RXDATA_OFFSET >> 2);
  wire wr_hit   = (aw_addr[7:2] == `CTRL_OFFSET >> 2)
                  | (aw_addr[7:2] == `TXDATA_OFFSET >> 2)
                  | (aw_addr[7:2] == `RXDATA_OFFSET >> 2)
                  | (aw_addr[7:2] == `STATUS_OFFSET >> 2);

  assign s_axi_awready_o = ~aw_held & ~s_axi_bvalid_o;
  assign s_axi_wready_o  = ~w_held & ~s_axi_bvalid_o;
  assign s_axi_arready_o = ~s_axi_rvalid_o;

  // Pin drivers
  assign tx_bitclk_pin_o    = ~(clk_level ^ tx_bitclk_polarity);
  assign tx_bitclk_pin_oe_o = tx_bitclk_dir;
  assign tx_sync_pin_o      = sync_active ^ tx_sync_polarity;
  assign tx_sync_pin_oe_o   = tx_sync_dir;

  pin_sync3 #(
    .W (4)
  ) u_pin_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .pin_i     ({serial_in_pin_i, rx_sync_pin_i, tx_sync_pin_i, tx_bitclk_pin_i}),
    .level_o   (pins_sync)
  );

  // Control register byte-lane merge
  always @* begin
    next_ctrl = ctrl;
    for (b = 0; b < 4; b = b + 1) begin
      if (w_strb[b]) begin
        next_ctrl[b*8 +: 8] = w_data[b*8 +: 8];
      end
    end
  end

  // Read data selection
  always @* begin
    read_mux = 32'h0000_0000;
    read_hit = 1'b1;
    case (s_axi_araddr_i[7:2])
      `CTRL_OFFSET >> 2:   read_mux = ctrl;
      `TXDATA_OFFSET >> 2: read_mux = {24'h00_0000, tx_word};
      `RXDATA_OFFSET >> 2: read_mux = {24'h00_0000, rx_word};
      `STATUS_OFFSET >> 2: begin
        read_mux[`STAT_BUSY_BIT]   = (state != ST_IDLE);
        read_mux[`STAT_RXRDY_BIT]  = rx_ready;
        read_mux[`STAT_CFGERR_BIT] = cfg_error;
        read_mux[`STAT_MASTER_BIT] = master_mode;
        read_mux[`STAT_TXPEND_BIT] = tx_pending;
      end
      default: read_hit = 1'b0;
    endcase
  end

  // AXI4-Lite slave
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      aw_held        <= 1'b0;
      w_held         <= 1'b0;
      aw_addr        <= 8'h00;
      w_data         <= 32'h0000_0000;
      w_strb         <= 4'h0;
      ctrl           <= `CTRL_RESET;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= `RESP_OKAY;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rresp_o  <= `RESP_OKAY;
      s_axi_rdata_o  <= 32'h0000_0000;
    end else begin
      if (aw_hs) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end
      if (w_hs) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
      if (do_write) begin
        aw_held        <= 1'b0;
        w_held         <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        if (wr_ctrl) begin
          ctrl <= next_ctrl;
        end
      end else if (s_axi_bvalid_o & s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
      if (ar_hs) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o  <= read_mux;
        s_axi_rresp_o  <= read_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid_o & s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  // Transfer engine for master and slave operation
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      state               <= ST_IDLE;
      cnt                 <= 9'h000;
      bit_cnt             <= 4'h0;
      tx_shift            <= 8'h00;
      rx_shift            <= 8'h00;
      tx_word             <= `TXDATA_RESET;
      tx_pending          <= 1'b0;
      rx_word             <= `RXDATA_RESET;
      rx_ready            <= 1'b0;
      clk_level           <= 1'b1;
      sync_active         <= 1'b0;
      prev_nclk           <= 1'b0;
      serial_out_pin_o    <= 1'b0;
      serial_out_pin_oe_o <= 1'b0;
    end else begin
      prev_nclk <= nclk;
      if (rx_read) begin
        rx_ready <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          clk_level <= 1'b1;
          if (master_mode & tx_pending) begin
            sync_active         <= 1'b1;
            tx_pending          <= 1'b0;
            tx_shift            <= tx_word;
            serial_out_pin_o    <= tx_word[7];
            serial_out_pin_oe_o <= 1'b1;
            bit_cnt             <= 4'h0;
            cnt                 <= period - 9'h001;
            state               <= ST_HIGH;
          end else if (slave_mode & tx_act) begin
            tx_pending          <= 1'b0;
            tx_shift            <= tx_word;
            serial_out_pin_o    <= tx_word[7];
            serial_out_pin_oe_o <= 1'b1;
            bit_cnt             <= 4'h0;
            state               <= ST_SLAVE;
          end
        end
        ST_HIGH: begin
          if (~master_mode) begin
            serial_out_pin_oe_o <= 1'b0;
            sync_active         <= 1'b0;
            state               <= ST_IDLE;
          end else if (cnt == 9'h000) begin
            clk_level <= 1'b0;
            rx_shift  <= {rx_shift[6:0], s_in};
            bit_cnt   <= bit_cnt + 4'h1;
            cnt       <= low_len - 9'h001;
            state     <= ST_LOW;
          end else begin
            cnt <= cnt - 9'h001;
          end
        end
        ST_LOW: begin
          if (~master_mode) begin
            clk_level           <= 1'b1;
            serial_out_pin_oe_o <= 1'b0;
            sync_active         <= 1'b0;
            state               <= ST_IDLE;
          end else if (cnt == 9'h000) begin
            clk_level <= 1'b1;
            cnt       <= high_len - 9'h001;
            if (bit_cnt == `WORD_BITS) begin
              serial_out_pin_oe_o <= 1'b0;
              rx_word             <= rx_shift;
              rx_ready            <= 1'b1;
              state               <= ST_TAIL;
            end else begin
              tx_shift         <= {tx_shift[6:0], 1'b0};
              serial_out_pin_o <= tx_shift[6];
              state            <= ST_HIGH;
            end
          end else begin
            cnt <= cnt - 9'h001;
          end
        end
        ST_TAIL: begin
          if ((cnt == 9'h000) | ~master_mode) begin
            sync_active <= 1'b0;
            state       <= ST_IDLE;
          end else begin
            cnt <= cnt - 9'h001;
          end
        end
        ST_SLAVE: begin
          if (~tx_act | ~slave_mode) begin
            serial_out_pin_oe_o <= 1'b0;
            state               <= ST_IDLE;
          end else if (s_fall & rx_act & (bit_cnt != `WORD_BITS)) begin
            rx_shift <= {rx_shift[6:0], s_in};
            bit_cnt  <= bit_cnt + 4'h1;
            if (bit_cnt == `WORD_BITS - 4'h1) begin
              rx_word  <= {rx_shift[6:0], s_in};
              rx_ready <= 1'b1;
            end
          end else if (s_rise & (bit_cnt != 4'h0)) begin
            if (bit_cnt == `WORD_BITS) begin
              serial_out_pin_oe_o <= 1'b0;
            end else begin
              tx_shift         <= {tx_shift[6:0], 1'b0};
              serial_out_pin_o <= tx_shift[6];
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      if (tx_write) begin
        tx_word    <= w_data[7:0];
        tx_pending <= 1'b1;
      end
    end
  end

endmodule // clock_stop_spi_port

`default_nettype wire

//--- core/clock_stop_spi_port_map.vh
// Register map, field positions and constants of the clock-stop SPI port
`ifndef CLOCK_STOP_SPI_PORT_MAP_VH
`define CLOCK_STOP_SPI_PORT_MAP_VH

`define CTRL_OFFSET      8'h00
`define TXDATA_OFFSET    8'h04
`define RXDATA_OFFSET    8'h08
`define STATUS_OFFSET    8'h0C

`define CTRL_RESET       32'h0000_0000
`define TXDATA_RESET     8'h00
`define RXDATA_RESET     8'h00

`define CTRL_CLKPOL_BIT  0
`define CTRL_TXPOL_BIT   1
`define CTRL_RXPOL_BIT   2
`define CTRL_TXCLKD_BIT  3
`define CTRL_RXCLKD_BIT  4
`define CTRL_TXSYND_BIT  5
`define CTRL_RXSYND_BIT  6
`define CTRL_SRCSEL_BIT  7
`define CTRL_STOP_LSB    8
`define CTRL_STOP_MSB    9
`define CTRL_DIV_LSB     16
`define CTRL_DIV_MSB     23

`define STAT_BUSY_BIT    0
`define STAT_RXRDY_BIT   1
`define STAT_CFGERR_BIT  2
`define STAT_MASTER_BIT  3
`define STAT_TXPEND_BIT  4

`define STOP_MODE_LATE   2'b11
`define SLAVE_RATE_DIV   8'h01
`define WORD_BITS        4'h8

`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

//--- core/pin_sync3.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none

module pin_sync3 #(
  parameter W = 4
) (
  input  wire         sys_clk_i,
  input  wire         rst_i,
  input  wire [W-1:0] pin_i,
  output reg  [W-1:0] level_o
);

  reg [W-1:0] stage1;
  reg [W-1:0] stage2;
  reg [W-1:0] stage3;
  integer     k;

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      stage1  <= {W{1'b0}};
      stage2  <= {W{1'b0}};
      stage3  <= {W{1'b0}};
      level_o <= {W{1'b0}};
    end else begin
      stage1 <= pin_i;
      stage2 <= stage1;
      stage3 <= stage2;
      // Change accepted once second and third stage agree
      for (k = 0; k < W; k = k + 1) begin
        if (stage2[k] == stage3[k]) begin
          level_o[k] <= stage3[k];
        end
      end
    end
  end

endmodule // pin_sync3

`default_nettype wire

//--- verification/clock_stop_spi_port_properties.sv
// Port assertions for the clock-stop SPI port
`timescale 1ns/1ns
`default_nettype none
module clock_stop_spi_port_properties (
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic        tx_bitclk_pin_o,
  input wire logic        tx_bitclk_pin_oe_o,
  input wire logic        tx_sync_pin_o,
  input wire logic        tx_sync_pin_oe_o,
  input wire logic        serial_out_pin_o,
  input wire logic        serial_out_pin_oe_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
    && s_axi_wready_o |-> ##2 s_axi_bvalid_o) else $error("write response late");
  a_bresp_holds: assert property (s_axi_bvalid_o && !s_axi_bready_i
    |=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read response late");
  a_rdata_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data dropped");
  a_sync_before_clock: assert property (
    $fell(tx_sync_pin_o) && tx_sync_pin_oe_o |-> tx_bitclk_pin_o ##1 tx_bitclk_pin_o)
    else $error("clock moved before enable");
  a_enable_low: assert property (
    serial_out_pin_oe_o && tx_bitclk_pin_oe_o |-> !tx_sync_pin_o)
    else $error("enable not low in transfer");
  a_idle_clock_high: assert property (
    tx_bitclk_pin_oe_o && tx_sync_pin_oe_o && tx_sync_pin_o |-> tx_bitclk_pin_o)
    else $error("clock not idle");
  a_launch_on_rise: assert property (
    serial_out_pin_oe_o && $past(serial_out_pin_oe_o) && tx_bitclk_pin_oe_o
    && $changed(serial_out_pin_o) |-> $rose(tx_bitclk_pin_o)) else $error("data off rise");
  a_release_on_rise: assert property (
    $fell(serial_out_pin_oe_o) && tx_bitclk_pin_oe_o |-> $rose(tx_bitclk_pin_o))
    else $error("release off rise");
  a_master_dirs: assert property (
    tx_bitclk_pin_oe_o == tx_sync_pin_oe_o) else $error("direction mismatch");
  cover property ($fell(tx_sync_pin_o) && tx_sync_pin_oe_o);
  cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'b10);
  cover property ($fell(serial_out_pin_oe_o));
  cover property ($rose(serial_out_pin_oe_o) && !tx_bitclk_pin_oe_o);
endmodule // clock_stop_spi_port_properties
bind clock_stop_spi_port clock_stop_spi_port_properties props (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
  .tx_bitclk_pin_o(tx_bitclk_pin_o), .tx_bitclk_pin_oe_o(tx_bitclk_pin_oe_o),
  .tx_sync_pin_o(tx_sync_pin_o), .tx_sync_pin_oe_o(tx_sync_pin_oe_o),
  .serial_out_pin_o(serial_out_pin_o), .serial_out_pin_oe_o(serial_out_pin_oe_o));
`default_nettype wire

//--- verification/spi_slave_model.sv
// External SPI slave device model
`timescale 1ns/1ns
`default_nettype none
module spi_slave_model (
  input  wire logic       bitclk_i,
  input  wire logic       sync_n_i,
  input  wire logic       sdi_i,
  input  wire logic       slow_i,
  input  wire logic [7:0] tx_i,
  output var  logic       miso_o,
  output var  logic [7:0] rx_o
);
  logic [7:0] sh;
  int         n;
  initial begin
    miso_o = 1'b1;
    rx_o = 8'h00;
    n = 0;
  end
  always @(negedge sync_n_i) begin
    sh = tx_i;
    n = 0;
    miso_o = tx_i[7];
  end
  always @(posedge sync_n_i) miso_o = ~miso_o;
  always @(negedge bitclk_i) begin
    if (!sync_n_i && n < 8) begin
      rx_o = {rx_o[6:0], sdi_i};
      n = n + 1;
    end
  end
  always @(posedge bitclk_i) begin
    if (!sync_n_i && n > 0 && n < 8) begin
      sh = sh << 1;
      #(slow_i ? 3 : 1);
      miso_o = sh[7];
    end
  end
endmodule // spi_slave_model
`default_nettype wire

//--- verification/clock_stop_spi_port_tb_top.sv
// Self-checking bench for the clock-stop SPI port
`timescale 1ns/1ns
`default_nettype none
`include "clock_stop_spi_port_map.vh"
module clock_stop_spi_port_tb_top;
  logic        sys_clk_i, rst_i, awvalid, wvalid, bready, arvalid, rready, slow;
  logic        ext_clk, ext_sync_n;
  logic [7:0]  awaddr, araddr, part_tx;
  logic [31:0] wdata;
  wire  [31:0] rdata;
  wire  [1:0]  bresp, rresp;
  wire         awready, wready, bvalid, arready, rvalid;
  wire         bclk_o, bclk_oe, sync_o, sync_oe, sdo, sdo_oe, miso;
  wire  [7:0]  slave_rx;
  wire         bclk_w = bclk_oe ? bclk_o : ext_clk;
  wire         sync_w = sync_oe ? sync_o : ext_sync_n;
  int          bad_count, check_count;
  int          divs[6] = '{0, 1, 2, 3, 4, 8};
  clock_stop_spi_port dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .tx_bitclk_pin_i(bclk_w), .tx_bitclk_pin_o(bclk_o),
    .tx_bitclk_pin_oe_o(bclk_oe), .tx_sync_pin_i(sync_w), .tx_sync_pin_o(sync_o),
    .tx_sync_pin_oe_o(sync_oe), .rx_sync_pin_i(sync_w), .serial_out_pin_o(sdo),
    .serial_out_pin_oe_o(sdo_oe), .serial_in_pin_i(miso));
  spi_slave_model partner (.bitclk_i(bclk_w), .sync_n_i(sync_w), .sdi_i(sdo),
    .slow_i(slow), .tx_i(part_tx), .miso_o(miso), .rx_o(slave_rx));
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input string name, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int t;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    t = 0;
    do begin
      @(posedge sys_clk_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      t++;
    end while (bvalid !== 1'b1 && t < 100);
    r = bresp;
    bready <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int t;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    t = 0;
    do begin
      @(posedge sys_clk_i);
      if (arvalid && arready) arvalid <= 1'b0;
      t++;
    end while (rvalid !== 1'b1 && t < 100);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(n, d, e);
  endtask
  task automatic hold(input logic sig_sel, input logic lvl, output int n);
    n = 0;
    while ((sig_sel ? sync_o : bclk_o) === lvl && n < 1000) begin
      n++;
      @(posedge sys_clk_i);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    int          per, lo, hi, d;
    logic [31:0] v;
    logic [1:0]  r;
    logic [7:0]  sent;
    rst_i = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, slow} = '0;
    {awaddr, araddr, wdata, part_tx} = '0;
    {ext_clk, ext_sync_n} = 2'b11;
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    rchk("ctrl reset", `CTRL_OFFSET, `CTRL_RESET);
    rchk("status reset", `STATUS_OFFSET, 32'h0000_0004);
    wr(8'h10, 32'hFFFF_FFFF, r);
    chk("unmapped bresp", r, `RESP_SLVERR);
    rd(8'h14, v, r);
    chk("unmapped rresp", r, `RESP_SLVERR);
    chk("unmapped rdata", v, 32'h0000_0000);
    wr(`CTRL_OFFSET, 32'h0001_0387, r);
    rchk("slave status", `STATUS_OFFSET, 32'h0000_0000);
    chk("slave drives", {bclk_oe, sync_oe, sdo_oe}, 32'h0);
    wr(`CTRL_OFFSET, 32'h0002_0387, r);
    rchk("slave divide two", `STATUS_OFFSET, 32'h0000_0004);
    wr(`CTRL_OFFSET, 32'h0001_0307, r);
    rchk("slave source", `STATUS_OFFSET, 32'h0000_0004);
    foreach (divs[i]) begin
      d = (divs[i] == 0) ? 1 : divs[i];
      sent = 8'h3C ^ divs[i][7:0];
      slow <= (divs[i] == 8);
      part_tx <= ~sent;
      wr(`CTRL_OFFSET, {8'h00, divs[i][7:0], 16'h032F}, r);
      chk("master dirs", {bclk_oe, sync_oe}, 32'h3);
      chk("enable idle", sync_o, 32'h1);
      wr(`TXDATA_OFFSET, {24'h0, sent}, r);
      hold(1'b1, 1'b1, per);
      hold(1'b0, 1'b1, per);
      hold(1'b0, 1'b0, lo);
      hold(1'b0, 1'b1, hi);
      chk("first high", per, d + 1);
      chk("low phase", lo, (d >> 1) + (d & 1));
      chk("high phase", hi, (d >> 1) + 1);
      chk("period", lo + hi, d + 1);
      hold(1'b1, 1'b0, per);
      chk("idle clock", bclk_o, 32'h1);
      chk("output released", sdo_oe, 32'h0);
      chk("slave word", slave_rx, sent);
      if (divs[i] == 8) begin
        rchk("status ready", `STATUS_OFFSET, 32'h0000_000A);
        rchk("rx word", `RXDATA_OFFSET, {24'h0, ~sent});
        rchk("status read", `STATUS_OFFSET, 32'h0000_0008);
      end
    end
    // Slave transfer, bench acts as external master
    part_tx <= 8'hA5;
    wr(`CTRL_OFFSET, 32'h0001_0387, r);
    wr(`TXDATA_OFFSET, 32'h0000_005A, r);
    ext_sync_n <= 1'b0;
    repeat (12) @(posedge sys_clk_i);
    repeat (8) begin
      ext_clk <= 1'b0;
      repeat (12) @(posedge sys_clk_i);
      ext_clk <= 1'b1;
      repeat (12) @(posedge sys_clk_i);
    end
    chk("slave mode released", sdo_oe, 32'h0);
    ext_sync_n <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    chk("slave mode shift out", slave_rx, 32'h0000_005A);
    rchk("slave mode shift in", `RXDATA_OFFSET, 32'h0000_00A5);
    end_sim;
  end
  initial begin
    #100000;
    bad_count++;
    end_sim;
  end
endmodule // clock_stop_spi_port_tb_top
`default_nettype wire
